// [doorc_cfg.svh]
`ifndef DOORC_CFG_SVH
`define DOORC_CFG_SVH

// Clock rate of clk in Hz.
`define DOORC_CLK_HZ 64'd250_000_000

// Exit window after business hours, in seconds.
`define DOORC_EXIT_WINDOW_S 64'd3600
// Warning buzzer pulse, in milliseconds.
`define DOORC_BUZZ_MS 64'd1000
// Default minimum quiet time before closing, in milliseconds.
`define DOORC_CLOSE_DELAY_MS 64'd3000

// Derived cycle counts (millisecond times round down, all well above one cycle).
`define DOORC_EXIT_WINDOW_CYC (`DOORC_EXIT_WINDOW_S * `DOORC_CLK_HZ)
`define DOORC_BUZZ_CYC ((`DOORC_BUZZ_MS * `DOORC_CLK_HZ) / 64'd1000)
`define DOORC_CLOSE_DELAY_CYC ((`DOORC_CLOSE_DELAY_MS * `DOORC_CLK_HZ) / 64'd1000)

// Width of the timing counters; one hour at 250 MHz needs 40 bits.
`define DOORC_CNT_W 40

// Motion state encodings.
`define DOORC_MOTION_IDLE 2'h0
`define DOORC_MOTION_OPENING 2'h1
`define DOORC_MOTION_CLOSING 2'h2

`endif

// [doorc_controller.sv]
`timescale 1ns/1ps
`include "doorc_cfg.svh"

// Overview of operation
// - Open motor on permanent-open or qualified motion.
// - Release open motor at open limit.
// - Close motor on permanent-closed or nobody near.
// - Release close motor at closed limit.
// - Outside sensor opens during business hours.
// - Inside sensor opens during business hours.
// - Inside sensor still accepted one hour after closing.
// - One-second buzzer pulse when closing starts.
// - In automatic mode, hold open while any sensor reports accepted presence.
// - In automatic mode, close only after configurable quiet delay.
module doorc_controller
   import doorc_pkg::*;
#(
   parameter logic [`DOORC_CNT_W-1:0] EXIT_WINDOW_CYCLES =
      `DOORC_CNT_W'(`DOORC_EXIT_WINDOW_CYC),
   parameter logic [`DOORC_CNT_W-1:0] BUZZ_CYCLES =
      `DOORC_CNT_W'(`DOORC_BUZZ_CYC),
   parameter logic [`DOORC_CNT_W-1:0] CLOSE_DELAY_CYCLES =
      `DOORC_CNT_W'(`DOORC_CLOSE_DELAY_CYC)
) (
   // Clock and reset.
   input wire logic clk,
   input wire logic rst_b,
   // Sensors and limit switches.
   input wire logic outside_motion_in,
   input wire logic inside_motion_in,
   input wire logic closed_limit_in,
   input wire logic open_limit_in,
   // Control switch and time condition.
   input wire logic perm_open_sw_in,
   input wire logic perm_closed_sw_in,
   input wire logic business_hours_in,
   // Actuators.
   output logic open_motor_out,
   output logic close_motor_out,
   output logic warn_buzzer_out
);

   // The counters cannot serve a zero length for any timed interval.
   if (EXIT_WINDOW_CYCLES == '0) begin : g_bad_exit
      $error("doorc_controller: EXIT_WINDOW_CYCLES must be at least 1");
   end
   if (BUZZ_CYCLES == '0) begin : g_bad_buzz
      $error("doorc_controller: BUZZ_CYCLES must be at least 1");
   end
   if (CLOSE_DELAY_CYCLES == '0) begin : g_bad_delay
      $error("doorc_controller: CLOSE_DELAY_CYCLES must be at least 1");
   end

   // Motor drive bits for a motion state; opening and closing exclude each other.
   function automatic doorc_drive_type motor_drive(input doorc_motion_type m);
      doorc_drive_type d;
      d = '0;
      d.open_motor = (m == DOORC_OPENING);
      d.close_motor = (m == DOORC_CLOSING);
      return d;
   endfunction

   logic rst_meta_b;
   logic rst_sync_b;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rst_meta_b <= 1'b0;
         rst_sync_b <= 1'b0;
      end else begin
         rst_meta_b <= 1'b1;
         rst_sync_b <= rst_meta_b;
      end
   end

   doorc_pins_type pins;
   doorc_state_type state;
   doorc_state_type next_state;

   always_comb begin
      pins.outside_motion = outside_motion_in;
      pins.inside_motion = inside_motion_in;
      pins.closed_limit = closed_limit_in;
      pins.open_limit = open_limit_in;
      pins.perm_open_sw = perm_open_sw_in;
      pins.perm_closed_sw = perm_closed_sw_in;
      pins.business_hours = business_hours_in;
   end

   logic hours;
   logic exit_window;
   logic outside_ok;
   logic inside_ok;
   logic presence;
   logic quiet_done;
   logic auto_mode;
   logic open_req;
   logic close_req;

   always_comb begin
      hours = state.sync.business_hours;
      exit_window = (state.exit_cnt != '0);
      // Outside detections count only during business hours.
      outside_ok = state.sync.outside_motion & hours;
      // Inside detections count during hours and the exit window.
      inside_ok = state.sync.inside_motion & (hours | exit_window);
      presence = outside_ok | inside_ok;
      quiet_done = (state.quiet_cnt >= CLOSE_DELAY_CYCLES);
      auto_mode = ~state.sync.perm_open_sw & ~state.sync.perm_closed_sw;
      open_req = state.sync.perm_open_sw | (auto_mode & presence);
      close_req = ~state.sync.perm_open_sw
         & (state.sync.perm_closed_sw | (auto_mode & quiet_done & ~presence));
   end

   always_comb begin
      next_state = state;
      next_state.sync_meta = pins;
      next_state.sync = state.sync_meta;
      next_state.hours_prev = hours;

      // Exit window starts when business hours end and runs one hour.
      if (hours) begin
         next_state.exit_cnt = '0;
      end else if (state.hours_prev) begin
         next_state.exit_cnt = EXIT_WINDOW_CYCLES;
      end else if (exit_window) begin
         next_state.exit_cnt = state.exit_cnt - 1'b1;
      end

      // Quiet timer restarts on any accepted presence.
      if (presence) begin
         next_state.quiet_cnt = '0;
      end else if (!quiet_done) begin
         next_state.quiet_cnt = state.quiet_cnt + 1'b1;
      end

      // Opening is checked first so it always wins over closing.
      if (open_req && !state.sync.open_limit) begin
         next_state.motion = DOORC_OPENING;
      end else if (close_req && !state.sync.closed_limit) begin
         next_state.motion = DOORC_CLOSING;
      end else begin
         next_state.motion = DOORC_IDLE;
      end

      // The buzzer pulse starts with each new closing motion.
      if (next_state.motion == DOORC_CLOSING && state.motion != DOORC_CLOSING) begin
         next_state.buzz_cnt = BUZZ_CYCLES;
      end else if (state.buzz_cnt != '0) begin
         next_state.buzz_cnt = state.buzz_cnt - 1'b1;
      end

      next_state.drive = motor_drive(next_state.motion);
      next_state.drive.warn_buzzer = (next_state.buzz_cnt != '0);
   end

   always_ff @(posedge clk or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   assign open_motor_out = state.drive.open_motor;
   assign close_motor_out = state.drive.close_motor;
   assign warn_buzzer_out = state.drive.warn_buzzer;

endmodule // doorc_controller

// [doorc_door.sv]
`timescale 1ns/1ps
module doorc_door #(
   parameter int TRAVEL = 6
) (
   // Clock and contactors.
   input wire logic clk,
   input wire logic open_motor_out,
   input wire logic close_motor_out,
   // Limit switches.
   output logic closed_limit_in,
   output logic open_limit_in
);
   int pos = 0;
   // The leaf moves one step a cycle and the slip coupling stops it at either end.
   always @(posedge clk) begin
      pos <= #1 open_motor_out ? (pos < TRAVEL ? pos + 1 : pos) :
         ((close_motor_out && pos > 0) ? pos - 1 : pos);
   end
   assign closed_limit_in = (pos == 0);
   assign open_limit_in = (pos == TRAVEL);
endmodule // doorc_door

// [doorc_pkg.sv]
`include "doorc_cfg.svh"

package doorc_pkg;

   typedef logic [`DOORC_CNT_W-1:0] doorc_count_type;

   typedef enum logic [1:0] {
      DOORC_IDLE = `DOORC_MOTION_IDLE,
      DOORC_OPENING = `DOORC_MOTION_OPENING,
      DOORC_CLOSING = `DOORC_MOTION_CLOSING
   } doorc_motion_type;

   typedef struct packed {
      logic outside_motion;
      logic inside_motion;
      logic closed_limit;
      logic open_limit;
      logic perm_open_sw;
      logic perm_closed_sw;
      logic business_hours;
   } doorc_pins_type;

   typedef struct packed {
      logic open_motor;
      logic close_motor;
      logic warn_buzzer;
   } doorc_drive_type;

   typedef struct packed {
      doorc_pins_type sync_meta;
      doorc_pins_type sync;
      logic hours_prev;
      doorc_count_type exit_cnt;
      doorc_count_type quiet_cnt;
      doorc_count_type buzz_cnt;
      doorc_motion_type motion;
      doorc_drive_type drive;
   } doorc_state_type;

endpackage

// [doorc_props.sv]
`timescale 1ns/1ps
module doorc_props
   import doorc_pkg::*;
#(
   parameter logic [39:0] BUZZ_CYCLES = 40'h00A,
   parameter logic [39:0] CLOSE_DELAY_CYCLES = 40'h014
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic outside_motion_in,
   input wire logic inside_motion_in,
   input wire logic closed_limit_in,
   input wire logic open_limit_in,
   input wire logic perm_open_sw_in,
   input wire logic perm_closed_sw_in,
   input wire logic business_hours_in,
   input wire logic open_motor_out,
   input wire logic close_motor_out,
   input wire logic warn_buzzer_out
);
   logic [2:0] age;
   logic [39:0] bcnt;
   logic [39:0] qcnt;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   // Age masks the start-up cycles; the counters time buzzer and quiet spans.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         age <= 3'h0;
         bcnt <= 40'h0;
         qcnt <= 40'h0;
      end else begin
         age <= (age == 3'h7) ? age : age + 3'h1;
         bcnt <= warn_buzzer_out ? bcnt + 40'h1 : 40'h0;
         qcnt <= (inside_motion_in || (outside_motion_in && business_hours_in)) ? 40'h0 :
            qcnt + 40'h1;
      end
   end
   sequence s_perm_open;
      (perm_open_sw_in && !open_limit_in)[*3];
   endsequence
   sequence s_close_start;
      $rose(close_motor_out) && !$past(perm_closed_sw_in, 3);
   endsequence
   a_motor_excl: assert property (!(open_motor_out && close_motor_out))
      else $error("both motors driven");
   a_open_stop: assert property (open_limit_in[*3] |=> !open_motor_out)
      else $error("open motor past open limit");
   a_close_stop: assert property (closed_limit_in[*3] |=> !close_motor_out)
      else $error("close motor past closed limit");
   a_buzz_start: assert property ($rose(close_motor_out) |-> warn_buzzer_out)
      else $error("no buzzer at closing start");
   a_buzz_length: assert property ($fell(warn_buzzer_out) |-> bcnt == BUZZ_CYCLES)
      else $error("buzzer pulse length wrong");
   a_perm_open: assert property (age == 3'h7 ##0 s_perm_open |=> open_motor_out)
      else $error("permanent open not driven");
   a_open_cause: assert property ($rose(open_motor_out) |-> $past(perm_open_sw_in, 3) ||
      $past(inside_motion_in, 3) || ($past(outside_motion_in, 3) && $past(business_hours_in, 3)))
      else $error("opening without a valid request");
   a_quiet_close: assert property (s_close_start |-> qcnt >= CLOSE_DELAY_CYCLES)
      else $error("closing before quiet delay");
endmodule // doorc_props
bind doorc_controller doorc_props #(.BUZZ_CYCLES(BUZZ_CYCLES),
   .CLOSE_DELAY_CYCLES(CLOSE_DELAY_CYCLES)) doorc_props_i (.clk, .rst_b, .outside_motion_in,
   .inside_motion_in, .closed_limit_in, .open_limit_in, .perm_open_sw_in, .perm_closed_sw_in,
   .business_hours_in, .open_motor_out, .close_motor_out, .warn_buzzer_out);

// [tb_doorc_controller.sv]
`timescale 1ns/1ps
module tb_doorc_controller;
   logic clk = 1'b0, rst_b = 1'b0, outside_motion_in = 1'b0, inside_motion_in = 1'b0;
   logic perm_open_sw_in = 1'b0, perm_closed_sw_in = 1'b0, business_hours_in = 1'b0;
   logic closed_limit_in, open_limit_in, open_motor_out, close_motor_out, warn_buzzer_out;
   logic req, prev = 1'b0, hp = 1'b0;
   int failures = 0, checked = 0, win = 0, bz = 0, exp_bz = 0, cyc = 0;
   doorc_controller #(.EXIT_WINDOW_CYCLES(40'h0C8), .BUZZ_CYCLES(40'h00A),
      .CLOSE_DELAY_CYCLES(40'h014)) doorc_controller_i (.clk, .rst_b, .outside_motion_in,
      .inside_motion_in, .closed_limit_in, .open_limit_in, .perm_open_sw_in,
      .perm_closed_sw_in, .business_hours_in, .open_motor_out, .close_motor_out,
      .warn_buzzer_out);
   doorc_door doorc_door_i (.clk, .open_motor_out, .close_motor_out, .closed_limit_in,
      .open_limit_in);
   initial begin
      forever #2 clk = ~clk;
   end
   task stop_test;
      $display("failures %0d checked %0d", failures, checked);
      if (failures == 0 && checked > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   // Model of the exit window, buzzer time and a cycle limit against hangs.
   always @(posedge clk) begin
      hp <= business_hours_in;
      win <= (hp && !business_hours_in) ? 200 : (win > 0 ? win - 1 : 0);
      bz <= bz + int'(warn_buzzer_out === 1'b1);
      cyc <= cyc + 1;
      if (cyc == 2000) begin
         failures++;
         stop_test;
      end
   end
   task step(input logic [4:0] v);
      @(posedge clk);
      #1 {perm_open_sw_in, perm_closed_sw_in, business_hours_in, outside_motion_in,
         inside_motion_in} = v;
      repeat (40) @(posedge clk);
      #1 req = v[4] || (!v[3] && ((v[0] && (v[2] || win > 0)) || (v[1] && v[2])));
      if (prev && !req) exp_bz += 10;
      prev = req;
      checked++;
      if ({open_limit_in, closed_limit_in, open_motor_out, close_motor_out} !==
         {req, !req, 2'h0}) begin
         failures++;
         $display("unexpected at %0t: door state", $time);
      end
   endtask
   initial begin
      void'($urandom(39));
      repeat (5) @(posedge clk);
      #1 rst_b = 1'b1;
      step(5'h04);
      step({3'h1, 2'($urandom_range(1, 3))});
      step(5'h04);
      step(5'h14);
      step(5'h0F);
      step(5'h00);
      step(5'h01);
      step(5'h00);
      repeat (200) @(posedge clk);
      step(5'h02);
      step(5'h01);
      checked++;
      if (bz !== exp_bz) begin
         failures++;
         $display("unexpected at %0t: buzzer time", $time);
      end
      stop_test;
   end
endmodule // tb_doorc_controller
